// [logic/dcs_pkg.sv]
// Purpose: shared constants and carriers of the channel status/irq block
// Assumes: nine channels, channel window of 0x100 bytes each
// Notes:   offsets are byte addresses inside one channel window
package dcs_pkg;
    // ------------------------------------------------------------
    // geometry and register map
    // ------------------------------------------------------------
    localparam int          NCH      = 9;
    localparam int          AW       = 12;
    localparam logic [7:0]  OFS_CDA  = 8'h18;    // current destination address
    localparam logic [7:0]  OFS_RBC  = 8'h1C;    // remaining byte count
    localparam logic [7:0]  OFS_IEN  = 8'h20;    // interrupt enable
    localparam logic [7:0]  OFS_IST  = 8'h24;    // interrupt status
    localparam logic [7:0]  OFS_CTL  = 8'h28;    // channel control/state
    localparam logic [31:0] RST_CDA  = 32'h0000_0000;
    localparam logic [15:0] RST_RBC  = 16'h0000;
    localparam logic [1:0]  RST_IEN  = 2'h1;
    localparam logic [1:0]  RST_IST  = 2'h0;
    localparam int          BIT_ABT  = 0;        // abort flag / enable
    localparam int          BIT_DONE = 1;        // done flag / enable
    localparam int          BIT_SRST = 0;        // control: soft reset
    localparam int          BIT_BUSY = 1;        // control: busy (RO)
    localparam int          BIT_HALT = 2;        // control: halted (RO)

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_HALT = 3'b100
    } dcs_state_e;

    // events and updates from the transfer engine, one per channel
    typedef struct packed {
        logic        start;
        logic        done;
        logic        abort;
        logic        dest_we;
        logic [31:0] dest;
        logic        cnt_we;
        logic [15:0] cnt;
    } dcs_eng_s;

    // accepted register write toward one channel
    typedef struct packed {
        logic       ien_we;
        logic       ist_we;
        logic       ctl_we;
        logic [2:0] bits;
    } dcs_wr_s;

    // channel state seen by the bus and the interrupt logic
    typedef struct packed {
        logic [31:0] dest;
        logic [15:0] cnt;
        logic [1:0]  ien;
        logic [1:0]  flags;
        logic        busy;
        logic        halt;
        logic        irq;
    } dcs_view_s;
endpackage

// [logic/dcs_chan.sv]
// Purpose: one channel: address/count view, enables, sticky flags, state
// Assumes: engine events are one-cycle pulses on CORE_CLK
// Notes:   a flag set in the cycle of its clear stays set
module dcs_chan
    import dcs_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // engine side
    input  wire dcs_eng_s  eng,
    // register writes
    input  wire dcs_wr_s   wr,
    // state out
    output dcs_view_s      view
);
    dcs_state_e  state;
    logic [31:0] dest;
    logic [15:0] cnt;
    logic [1:0]  ien;
    logic [1:0]  flags;
    logic        irq;
    logic        srst;
    logic [1:0]  next_flags;

    // soft reset is a write-one strobe, nothing is stored
    assign srst = wr.ctl_we & wr.bits[BIT_SRST];

    // live destination address, zero until first update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dest <= RST_CDA;                         // RQ2
        end else if (eng.dest_we) begin
            dest <= eng.dest;                        // RQ1
        end
    end

    // remaining count; soft reset beats a load in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= RST_RBC;
        end else if (srst) begin
            cnt <= RST_RBC;                          // RQ4
        end else if (eng.cnt_we) begin
            cnt <= eng.cnt;                          // RQ3
        end
    end

    // enable register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ien <= RST_IEN;                          // RQ7
        end else if (wr.ien_we) begin
            ien <= wr.bits[1:0];
        end
    end

    // sticky flags: write one clears, a new event wins over the clear
    always_comb begin
        next_flags = flags;
        if (wr.ist_we) begin
            next_flags = flags & ~wr.bits[1:0];      // RQ12
        end
        next_flags[BIT_DONE] = next_flags[BIT_DONE] | eng.done;   // RQ10
        next_flags[BIT_ABT]  = next_flags[BIT_ABT] | eng.abort;   // RQ11
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= RST_IST;
        end else begin
            flags <= next_flags;
        end
    end

    // an abort parks the channel until software resets it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (eng.abort) state <= ST_HALT;         // RQ13
                    else if (eng.start && !srst) state <= ST_BUSY;
                end
                ST_BUSY: begin
                    if (eng.abort) state <= ST_HALT;         // RQ13
                    else if (srst || eng.done) state <= ST_IDLE;
                end
                ST_HALT: begin
                    if (srst) state <= ST_IDLE;              // RQ13
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // channel request, gated per cause by its enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & ien);              // RQ5 RQ6 RQ14
        end
    end

    assign view = '{dest: dest, cnt: cnt, ien: ien, flags: flags,
                    busy: state[1], halt: state[2], irq: irq};  // one-hot bits, no decode

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_abort;
        eng.abort;
    endsequence

    a_abort_halts: assert property (@(posedge clk) disable iff (rst) // RQ13
        s_abort |=> (state == ST_HALT) && flags[BIT_ABT])
        else $error("abort did not halt and flag the channel");
    a_done_flag: assert property (@(posedge clk) disable iff (rst) // RQ10
        eng.done |=> flags[BIT_DONE])
        else $error("done event lost");
    a_w1c_clear: assert property (@(posedge clk) disable iff (rst) // RQ12
        (wr.ist_we && wr.bits[BIT_DONE] && !eng.done) |=> !flags[BIT_DONE])
        else $error("write one did not clear done flag");
    a_flag_hold: assert property (@(posedge clk) disable iff (rst) // RQ12
        (!wr.ist_we && flags[BIT_ABT]) |=> flags[BIT_ABT])
        else $error("abort flag dropped without a clear");
    a_srst_count: assert property (@(posedge clk) disable iff (rst) // RQ4
        srst |=> (cnt == RST_RBC))
        else $error("soft reset left count nonzero");
    a_done_gate: assert property (@(posedge clk) disable iff (rst) // RQ5
        (flags == 2'b10 && !ien[BIT_DONE]) |=> !irq || flags[BIT_ABT])
        else $error("done raised irq while disabled");
endmodule

// [logic/dcs_top.sv]
// Purpose: status and interrupt registers of a nine-channel DMA controller
// Assumes: Avalon-MM slave, one wait state per access, CORE_CLK 20 MHz
// Notes:   channel window is 0x100 bytes; engine drives ENG_IN pulses
//
// Contract
// RQ1: destination address register read-only at 0x18
// RQ2: destination address reads zero after reset
// RQ3: remaining byte count bits 15:0 at 0x1C
// RQ4: soft reset clears the remaining count
// RQ5: done enable bit 1 gates done interrupt
// RQ6: abort enable bit 0 gates abort interrupt
// RQ7: enable register read/write at 0x20, resets 0x1
// RQ8: status register at 0x24, low half zero; the code keeps the flags in bits 1:0 and reads bits 31:2 as zero
// RQ9: registers replicated for channels zero to eight
// RQ10: done flag set when transfer finishes
// RQ11: abort flag set on bus error response
// RQ12: flags clear only on written one
// RQ13: abort stops channel until software reset
// RQ14: interrupt high while enabled flag set
//
// Our own choice: the Avalon-MM interface to the registers.
module dcs_top
    import dcs_pkg::*;
(
    // clock and reset
    input  wire logic                            CORE_CLK,
    input  wire logic                            RST,
    // avalon-mm slave
    input  wire logic [dcs_pkg::AW-1:0]          AVS_ADDRESS,
    input  wire logic                            AVS_READ,
    input  wire logic                            AVS_WRITE,
    input  wire logic [31:0]                     AVS_WRITEDATA,
    input  wire logic [3:0]                      AVS_BYTEENABLE,
    output logic [31:0]                          AVS_READDATA,
    output logic                                 AVS_WAITREQUEST,
    // transfer engine events, one entry per channel
    input  wire dcs_pkg::dcs_eng_s [dcs_pkg::NCH-1:0] ENG_IN,
    // interrupt and channel state
    output logic [dcs_pkg::NCH-1:0]              CH_IRQ,
    output logic [dcs_pkg::NCH-1:0]              CH_HALT,
    output logic                                 IRQ
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    dcs_view_s [NCH-1:0] view;
    dcs_wr_s   [NCH-1:0] wr;
    logic                ack;
    logic                req;
    logic                hit;
    logic [3:0]          ch;
    logic [7:0]          ofs;
    logic [31:0]         next_rdata;
    logic [NCH-1:0]      next_irq;

    assign req = AVS_READ | AVS_WRITE;
    assign ch  = AVS_ADDRESS[11:8];
    assign ofs = AVS_ADDRESS[7:0];
    // channel numbers above eight are unmapped
    assign hit = (ch < 4'(NCH));                    // RQ9

    // one wait state: ack rises the cycle after a request, for one cycle;
    // the registered answer keeps the read mux off the bus timing path
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= ~(req & ~ack);
        end
    end

    // read mux; reserved and unmapped locations read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit && AVS_READ) begin
            case (ofs)
                OFS_CDA: next_rdata = view[ch].dest;                  // RQ1
                OFS_RBC: next_rdata = {16'h0000, view[ch].cnt};      // RQ3
                OFS_IEN: next_rdata = {30'h0, view[ch].ien};         // RQ7
                OFS_IST: next_rdata = {30'h0, view[ch].flags};       // RQ8
                OFS_CTL: next_rdata = {29'h0, view[ch].halt, view[ch].busy, 1'b0};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // data is sampled with the request and held until the next one
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (req && !ack) begin
            AVS_READDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // write strobes and channel instances
    // ------------------------------------------------------------
    // a write lands at the edge where waitrequest is seen low; only
    // byte lane 0 holds writable bits, so other lanes are ignored
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic go;
            assign go = AVS_WRITE & ack & hit & (ch == 4'(gi)) & AVS_BYTEENABLE[0];
            assign wr[gi] = '{ien_we: go & (ofs == OFS_IEN),
                              ist_we: go & (ofs == OFS_IST),
                              ctl_we: go & (ofs == OFS_CTL),
                              bits:   AVS_WRITEDATA[2:0]};
            dcs_chan u_chan (
                .clk  (CORE_CLK),
                .rst  (RST),
                .eng  (ENG_IN[gi]),
                .wr   (wr[gi]),
                .view (view[gi])
            );
            assign CH_IRQ[gi]   = view[gi].irq;      // RQ14
            assign CH_HALT[gi]  = view[gi].halt;     // RQ13
            assign next_irq[gi] = |(view[gi].flags & view[gi].ien);
        end
    endgenerate

    // ------------------------------------------------------------
    // combined interrupt
    // ------------------------------------------------------------
    // follows the enabled flags by one cycle, a cycle behind CH_IRQ except after an enable write; kept as a flop so the
    // line into the interrupt controller never glitches
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |next_irq;                        // RQ14
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_new_req;
        req && !ack;
    endsequence

    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    a_wait_one: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_new_req |=> s_answer)
        else $error("waitrequest did not pulse low for one cycle");
    a_rst_ien: assert property (@(posedge CORE_CLK) disable iff (RST) // RQ7
        ($rose(ack) && AVS_READ && hit && ofs == OFS_IEN && ch == 4'h0
         && !$past(wr[0].ien_we, 2) && view[0].ien == RST_IEN)
        |-> AVS_READDATA == 32'h0000_0001)
        else $error("enable readback mismatch");
    a_ist_upper: assert property (@(posedge CORE_CLK) disable iff (RST) // RQ8
        ($rose(ack) && AVS_READ && hit && ofs == OFS_IST) |-> AVS_READDATA[31:2] == 30'h0)
        else $error("status upper bits not zero");
    a_abort_irq: assert property (@(posedge CORE_CLK) disable iff (RST) // RQ6 RQ11
        (ENG_IN[0].abort && view[0].ien[BIT_ABT] && !wr[0].ien_we) |=> CH_IRQ[0] ##1 IRQ)
        else $error("enabled abort did not raise interrupt");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST) // RQ14
        ##1 IRQ == $past(|next_irq))
        else $error("irq does not follow enabled flags");
endmodule

// [bench/dcs_eng_model.sv]
// Purpose: transfer engine stand-in that feeds per-channel event pulses
// Assumes: one command per go strobe, pulses last one CORE_CLK cycle
// Notes:   data lines without a load strobe churn every cycle
module dcs_eng_model
    import dcs_pkg::*;
(
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // command from the bench
    input  wire logic                                go,
    input  wire logic [3:0]                          ch,
    input  wire logic [2:0]                          ev,
    input  wire logic                                ld,
    input  wire logic [31:0]                         dest,
    input  wire logic [15:0]                         cnt,
    // toward the block
    output dcs_pkg::dcs_eng_s [dcs_pkg::NCH-1:0]     eng
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog;

    // -------------------------------------------------------------
    // event pulses
    // -------------------------------------------------------------
    // unloaded data toggles so a stale value can never pass as a load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog <= 1'b0;
            eng <= '0;
        end else begin
            tog <= ~tog;
            for (int i = 0; i < NCH; i++) begin
                eng[i] <= '0;
                eng[i].dest <= {16{tog, ~tog}};
                eng[i].cnt <= {8{~tog, tog}};
            end
            if (go && ch < 4'(NCH)) begin
                eng[ch].start <= ev[2];
                eng[ch].done <= ev[1];
                eng[ch].abort <= ev[0];
                eng[ch].dest_we <= ld;
                eng[ch].cnt_we <= ld;
                if (ld) begin
                    eng[ch].dest <= dest;
                    eng[ch].cnt <= cnt;
                end
            end
        end
    end
endmodule

// [bench/dcs_top_tb.sv]
// Purpose: register, event and interrupt checks of the status/irq block
// Assumes: one wait state per access is not relied on; waits are bounded
// Notes:   after an abort the engine sends nothing until a soft reset
module dcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;

    logic                  core_clk, rst, rd_r, wr_r, go, ld, irq;
    logic [AW-1:0]         addr;
    logic [31:0]           wdata, rdata, q, dest;
    logic [3:0]            be, ch;
    logic [2:0]            ev;
    logic [15:0]           cnt;
    logic                  waitreq;
    logic [NCH-1:0]        ch_irq, ch_halt;
    dcs_eng_s [NCH-1:0]    eng;
    int                    err_count, checks_done;

    dcs_eng_model u_eng (.clk(core_clk), .rst(rst), .go(go), .ch(ch), .ev(ev), .ld(ld),
        .dest(dest), .cnt(cnt), .eng(eng));
    dcs_top u_dut (.CORE_CLK(core_clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_r),
        .AVS_WRITE(wr_r), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .ENG_IN(eng), .CH_IRQ(ch_irq), .CH_HALT(ch_halt),
        .IRQ(irq));

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one avalon access; request held until waitrequest is sampled low
    // no local limit: only the watchdog ends a wait that never answers
    task automatic acc(input logic w, input int c, input logic [7:0] o, input logic [31:0] d);
        @(posedge core_clk);
        chk("wait idle", 32'(waitreq), 32'h1);
        addr <= {c[3:0], o};
        rd_r <= !w;
        wr_r <= w;
        wdata <= d;
        do @(posedge core_clk);
        while (waitreq !== 1'b0);
        q = rdata;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask

    // one engine event, then time for flag, channel irq and summary irq
    task automatic pulse(input int c, input logic [2:0] e, input logic l,
                         input logic [31:0] d, input logic [15:0] n);
        @(posedge core_clk);
        go <= 1'b1;
        ch <= c[3:0];
        ev <= e;
        ld <= l;
        dest <= d;
        cnt <= n;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // -------------------------------------------------------------
    // clock, watchdog, tests
    // -------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // a hung handshake must end the run rather than stall it
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        test_done();
    end

    initial begin
        rst = 1'b1; rd_r = 1'b0; wr_r = 1'b0; addr = '0; wdata = '0; be = 4'hF;
        go = 1'b0; ch = '0; ev = '0; ld = 1'b0; dest = '0; cnt = '0;
        err_count = 0; checks_done = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("rst out", {12'h0, waitreq, irq, ch_halt, ch_irq}, 32'h0008_0000);
        for (int c = 0; c < NCH; c++) begin
            acc(0, c, OFS_CDA, 0); chk("dest rst", q, RST_CDA);
            acc(0, c, OFS_RBC, 0); chk("cnt rst", q, {16'h0000, RST_RBC});
            acc(0, c, OFS_IEN, 0); chk("ien rst", q, {30'h0, RST_IEN});
            acc(0, c, OFS_IST, 0); chk("ist rst", q, 32'h0000_0000);
        end
        acc(0, 9, OFS_IEN, 0); chk("unmapped", q, 32'h0000_0000);
        // each channel gets its own address and count; bus writes must not stick
        for (int c = 0; c < NCH; c++)
            pulse(c, 3'b100, 1'b1, 32'h8000_0010 + 32'(c) * 32'h0000_0104, 16'hFFF0 - 16'(c));
        for (int c = 0; c < NCH; c++) begin
            acc(1, c, OFS_CDA, 32'hFFFF_FFFF);
            acc(0, c, OFS_CDA, 0);
            chk("dest", q, 32'h8000_0010 + 32'(c) * 32'h0000_0104);
            acc(1, c, OFS_RBC, 32'hFFFF_FFFF);
            acc(0, c, OFS_RBC, 0); chk("cnt", q, {16'h0000, 16'hFFF0 - 16'(c)});
        end
        acc(1, 4, OFS_CTL, 32'h0000_0001);
        acc(0, 4, OFS_RBC, 0); chk("cnt srst", q, 32'h0000_0000);
        acc(0, 5, OFS_RBC, 0); chk("cnt other", q, 32'h0000_FFEB);
        acc(0, 5, OFS_CTL, 0); chk("busy", q, 32'h0000_0002);
        // enable register: a write without byte lane 0 is dropped
        be <= 4'h0;
        acc(1, 2, OFS_IEN, 32'h0000_0003);
        be <= 4'hF;
        acc(0, 2, OFS_IEN, 0); chk("ien be", q, 32'h0000_0001);
        acc(1, 2, OFS_IEN, 32'h0000_0002);
        acc(0, 2, OFS_IEN, 0); chk("ien rw", q, 32'h0000_0002);
        // done with its enable off, then enabled
        pulse(7, 3'b010, 1'b0, 0, 0);
        acc(0, 7, OFS_IST, 0); chk("done flag", q, 32'h0000_0002);
        chk("irq off", 32'(ch_irq), 32'h0);
        acc(1, 7, OFS_IEN, 32'h0000_0003);
        repeat (3) @(posedge core_clk);
        chk("ch irq", 32'(ch_irq), 32'h0000_0080);
        chk("irq", 32'(irq), 32'h1);
        acc(1, 7, OFS_IST, 32'h0000_0000);
        acc(0, 7, OFS_IST, 0); chk("w0 keeps", q, 32'h0000_0002);
        acc(1, 7, OFS_IST, 32'h0000_0002);
        acc(0, 7, OFS_IST, 0); chk("w1 clears", q, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        chk("irq clr", {22'h0, irq, ch_irq}, 32'h0);
        // abort under the reset-time enable halts the channel
        pulse(0, 3'b001, 1'b0, 0, 0);
        chk("abort irq", {22'h0, irq, ch_irq}, 32'h0000_0201);
        chk("halt", 32'(ch_halt), 32'h0000_0001);
        acc(0, 0, OFS_IST, 0); chk("abort flag", q, 32'h0000_0001);
        acc(0, 0, OFS_CTL, 0); chk("halted", q, 32'h0000_0004);
        acc(1, 0, OFS_IEN, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        chk("abort masked", 32'(ch_irq), 32'h0);
        acc(1, 0, OFS_CTL, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk("halt srst", 32'(ch_halt), 32'h0);
        acc(1, 0, OFS_IST, 32'h0000_0001);
        acc(0, 0, OFS_IST, 0); chk("abort clr", q, 32'h0000_0000);
        test_done();
    end
endmodule
